// >>> shared/afvc_pkg.sv
// Register map, field layout, reset values and timing constants of the audio filter and volume chain.
package afvc_pkg;
  localparam logic [7:0] AFVC_OFS_CTRL = 8'h00;
  localparam logic [7:0] AFVC_OFS_HP_COEF = 8'h04;
  localparam logic [7:0] AFVC_OFS_B1_AB = 8'h08;
  localparam logic [7:0] AFVC_OFS_B1_C = 8'h0c;
  localparam logic [7:0] AFVC_OFS_B2_AB = 8'h10;
  localparam logic [7:0] AFVC_OFS_B2_C = 8'h14;
  localparam logic [7:0] AFVC_OFS_IN_VOL = 8'h18;
  localparam logic [7:0] AFVC_OFS_OUT_VOL = 8'h1c;
  localparam logic [7:0] AFVC_OFS_STATUS = 8'h20;
  localparam logic [7:0] AFVC_OFS_SAMPLE = 8'h24;

  localparam int AFVC_BIT_CONV_HP_EN = 0;
  localparam int AFVC_BIT_PRE_EQ_HP_EN = 1;
  localparam int AFVC_BIT_CONV_PWR = 2;
  localparam int AFVC_BIT_FILT_PWR = 3;
  localparam int AFVC_BIT_BAND1_EN = 4;
  localparam int AFVC_BIT_BAND2_EN = 5;
  localparam int AFVC_BIT_PATH_SEL = 6;
  localparam int AFVC_BIT_REC_LC_EN = 7;
  localparam int AFVC_BIT_PLAY_LC_EN = 8;
  localparam int AFVC_POS_ZC_SEL = 9;
  localparam int AFVC_POS_ATT_SEL = 11;
  localparam int AFVC_CTRL_W = 13;
  localparam int AFVC_POS_COEF_HI = 16;

  localparam logic [AFVC_CTRL_W-1:0] AFVC_RST_CTRL = 13'h0040;
  localparam logic [7:0] AFVC_RST_VOL = 8'h91;
  localparam logic [7:0] AFVC_VOL_MAX = 8'hf1;
  localparam logic [7:0] AFVC_VOL_MUTE = 8'h00;

  localparam int AFVC_HP_COEF_W = 14;
  localparam int AFVC_EQ_COEF_W = 16;
  localparam int AFVC_COEF_FRAC = 13;
  localparam int AFVC_SAMPLE_W = 16;

  localparam logic [10:0] AFVC_ZC_BASE_SAMPLES = 11'h080;
  localparam logic [8:0] AFVC_VOL_BIAS = 9'h00f;
  localparam logic [4:0] AFVC_VOL_SHIFT_TOP = 5'h19;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HPC,
    ST_HPP,
    ST_EQ1,
    ST_EQ2,
    ST_VOL,
    ST_ATT
  } afvc_state_e;
endpackage

// >>> verilog/afvc_top.sv
// Audio sample chain: two high-pass stages, two equalizer bands, manual volume and attenuator, APB registers.
`timescale 1ns/100ps
module afvc_top
  import afvc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] sample_in,
  input wire logic sample_in_valid,
  output logic signed [15:0] sample_out,
  output logic sample_out_valid
);

  logic [AFVC_CTRL_W-1:0] ctrl_reg;
  logic signed [AFVC_HP_COEF_W-1:0] hp_coef_a_reg;
  logic signed [AFVC_HP_COEF_W-1:0] hp_coef_b_reg;
  logic signed [AFVC_EQ_COEF_W-1:0] band_coef_a_reg [2];
  logic signed [AFVC_EQ_COEF_W-1:0] band_coef_b_reg [2];
  logic signed [AFVC_EQ_COEF_W-1:0] band_coef_c_reg [2];
  logic [7:0] input_volume_code_reg;
  logic [7:0] output_volume_code_reg;
  logic [7:0] in_vol_applied_reg;
  logic [7:0] out_vol_applied_reg;
  logic [10:0] in_zc_cnt_reg;
  logic [10:0] out_zc_cnt_reg;
  logic signed [15:0] prev_vol_in_reg;
  afvc_state_e state_reg;
  logic signed [15:0] work_reg;
  logic signed [15:0] hpc_x_reg, hpc_y_reg, hpp_x_reg, hpp_y_reg;
  logic signed [15:0] eq_x1_reg [2];
  logic signed [15:0] eq_x2_reg [2];
  logic signed [15:0] eq_w1_reg [2];
  logic signed [15:0] eq_w2_reg [2];
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic signed [15:0] sample_out_reg;
  logic sample_out_valid_reg;

  logic conv_highpass_enable, pre_eq_highpass_enable, converter_power, filter_power;
  logic band_one_enable, band_two_enable, path_select;
  logic record_level_ctrl_enable, playback_level_ctrl_enable;
  logic [1:0] zero_cross_timeout_sel, playback_attenuator_sel;
  logic conv_hp_on, pre_hp_on, band_on [2];
  logic wr_en;
  logic in_restart, out_restart;
  logic in_pending, out_pending, zero_cross, vol_step;
  logic in_apply, out_apply;
  logic [10:0] zc_limit;
  logic [31:0] read_mux;
  logic signed [15:0] hp_result, eq_w, stage_out;
  logic [7:0] vol_code;

  assign conv_highpass_enable = ctrl_reg[AFVC_BIT_CONV_HP_EN];
  assign pre_eq_highpass_enable = ctrl_reg[AFVC_BIT_PRE_EQ_HP_EN];
  assign converter_power = ctrl_reg[AFVC_BIT_CONV_PWR];
  assign filter_power = ctrl_reg[AFVC_BIT_FILT_PWR];
  assign band_one_enable = ctrl_reg[AFVC_BIT_BAND1_EN];
  assign band_two_enable = ctrl_reg[AFVC_BIT_BAND2_EN];
  assign path_select = ctrl_reg[AFVC_BIT_PATH_SEL];
  assign record_level_ctrl_enable = ctrl_reg[AFVC_BIT_REC_LC_EN];
  assign playback_level_ctrl_enable = ctrl_reg[AFVC_BIT_PLAY_LC_EN];
  assign zero_cross_timeout_sel = ctrl_reg[AFVC_POS_ZC_SEL+:2];
  assign playback_attenuator_sel = ctrl_reg[AFVC_POS_ATT_SEL+:2];

  // A stage runs only with its enable and its power bit both set; the gate is not registered, so a change acts at once.
  assign conv_hp_on = conv_highpass_enable && converter_power;
  assign pre_hp_on = pre_eq_highpass_enable && filter_power;
  assign band_on[0] = band_one_enable && filter_power;
  assign band_on[1] = band_two_enable && filter_power;

  function automatic logic signed [15:0] afvc_sat(input logic signed [35:0] v);
    if (v > 36'sh00000_7fff) begin
      return 16'sh7fff;
    end else if (v < -36'sh00000_8000) begin
      return -16'sh8000;
    end else begin
      return v[15:0];
    end
  endfunction

  // First-order high-pass: y = A*(x - x_prev) + B*y_prev, coefficients in Q13.
  function automatic logic signed [15:0] afvc_highpass(
    input logic signed [15:0] x,
    input logic signed [15:0] xp,
    input logic signed [15:0] yp,
    input logic signed [AFVC_HP_COEF_W-1:0] a,
    input logic signed [AFVC_HP_COEF_W-1:0] b
  );
    logic signed [35:0] diff;
    logic signed [35:0] sum;
    diff = 36'(x) - 36'(xp);
    sum = 36'(a) * diff + 36'(b) * 36'(yp);
    return afvc_sat(sum >>> AFVC_COEF_FRAC);
  endfunction

  // Band-pass part of one band: w = A*(x - x2) + B*w1 + C*w2; the band output is x + w.
  function automatic logic signed [15:0] afvc_band(
    input logic signed [15:0] x,
    input logic signed [15:0] x2,
    input logic signed [15:0] w1,
    input logic signed [15:0] w2,
    input logic signed [AFVC_EQ_COEF_W-1:0] a,
    input logic signed [AFVC_EQ_COEF_W-1:0] b,
    input logic signed [AFVC_EQ_COEF_W-1:0] c
  );
    logic signed [35:0] sum;
    sum = 36'(a) * (36'(x) - 36'(x2)) + 36'(b) * 36'(w1) + 36'(c) * 36'(w2);
    return afvc_sat(sum >>> AFVC_COEF_FRAC);
  endfunction

  function automatic logic [15:0] afvc_mantissa(input logic [3:0] r);
    case (r)
      4'h0: return 16'h8000;
      4'h1: return 16'h85ab;
      4'h2: return 16'h8b96;
      4'h3: return 16'h91c4;
      4'h4: return 16'h9838;
      4'h5: return 16'h9ef5;
      4'h6: return 16'ha5ff;
      4'h7: return 16'had58;
      4'h8: return 16'hb505;
      4'h9: return 16'hbd09;
      4'ha: return 16'hc567;
      4'hb: return 16'hce25;
      4'hc: return 16'hd745;
      4'hd: return 16'he0cd;
      4'he: return 16'heac1;
      default: return 16'hf525;
    endcase
  endfunction

  // Sixteen codes per 6dB, so each code is close to 0.375dB; codes above the top clamp to +36dB.
  function automatic logic signed [15:0] afvc_volume(input logic signed [15:0] x, input logic [7:0] code);
    logic [8:0] e;
    logic [4:0] sh;
    logic signed [35:0] p;
    e = (code > AFVC_VOL_MAX) ? (9'(AFVC_VOL_MAX) + AFVC_VOL_BIAS) : (9'(code) + AFVC_VOL_BIAS);
    sh = AFVC_VOL_SHIFT_TOP - e[8:4];
    p = 36'(x) * $signed({20'h00000, afvc_mantissa(e[3:0])});
    if (code == AFVC_VOL_MUTE) begin
      return 16'sh0000;
    end else begin
      return afvc_sat(p >>> sh);
    end
  endfunction

  // APB slave: the answer is registered in the setup cycle, so pready is high in the first access cycle.
  always_comb begin
    read_mux = 32'h00000000;
    if (paddr == ADDR_W'(AFVC_OFS_CTRL)) begin
      read_mux = 32'(ctrl_reg);
    end else if (paddr == ADDR_W'(AFVC_OFS_HP_COEF)) begin
      read_mux = {2'b00, hp_coef_b_reg, 2'b00, hp_coef_a_reg};
    end else if (paddr == ADDR_W'(AFVC_OFS_B1_AB)) begin
      read_mux = {band_coef_b_reg[0], band_coef_a_reg[0]};
    end else if (paddr == ADDR_W'(AFVC_OFS_B1_C)) begin
      read_mux = {16'h0000, band_coef_c_reg[0]};
    end else if (paddr == ADDR_W'(AFVC_OFS_B2_AB)) begin
      read_mux = {band_coef_b_reg[1], band_coef_a_reg[1]};
    end else if (paddr == ADDR_W'(AFVC_OFS_B2_C)) begin
      read_mux = {16'h0000, band_coef_c_reg[1]};
    end else if (paddr == ADDR_W'(AFVC_OFS_IN_VOL)) begin
      read_mux = {24'h000000, input_volume_code_reg};
    end else if (paddr == ADDR_W'(AFVC_OFS_OUT_VOL)) begin
      read_mux = {24'h000000, output_volume_code_reg};
    end else if (paddr == ADDR_W'(AFVC_OFS_STATUS)) begin
      read_mux = {13'h0000, state_reg != ST_IDLE, out_pending, in_pending, out_vol_applied_reg, in_vol_applied_reg};
    end else if (paddr == ADDR_W'(AFVC_OFS_SAMPLE)) begin
      read_mux = {16'h0000, sample_out_reg};
    end
  end

  function automatic logic afvc_mapped(input logic [ADDR_W-1:0] a);
    if (a[1:0] != 2'b00) begin
      return 1'b0;
    end else if (a > ADDR_W'(AFVC_OFS_SAMPLE)) begin
      return 1'b0;
    end else begin
      return 1'b1;
    end
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      pready_reg <= 1'b1;
      prdata_reg <= pwrite ? 32'h00000000 : read_mux;
      pslverr_reg <= !afvc_mapped(paddr);
    end else if (psel && penable && pready_reg) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
  end

  assign wr_en = psel && penable && pwrite && pready_reg && !pslverr_reg;

  // Coefficients are taken whenever written; keeping the stage off meanwhile is software's duty.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= AFVC_RST_CTRL;
      hp_coef_a_reg <= '0;
      hp_coef_b_reg <= '0;
      band_coef_a_reg <= '{default: '0};
      band_coef_b_reg <= '{default: '0};
      band_coef_c_reg <= '{default: '0};
      input_volume_code_reg <= AFVC_RST_VOL;
      output_volume_code_reg <= AFVC_RST_VOL;
    end else if (wr_en) begin
      if (paddr == ADDR_W'(AFVC_OFS_CTRL)) begin
        ctrl_reg <= pwdata[AFVC_CTRL_W-1:0];
      end else if (paddr == ADDR_W'(AFVC_OFS_HP_COEF)) begin
        hp_coef_a_reg <= pwdata[AFVC_HP_COEF_W-1:0];
        hp_coef_b_reg <= pwdata[AFVC_POS_COEF_HI+:AFVC_HP_COEF_W];
      end else if (paddr == ADDR_W'(AFVC_OFS_B1_AB)) begin
        band_coef_a_reg[0] <= pwdata[15:0];
        band_coef_b_reg[0] <= pwdata[31:16];
      end else if (paddr == ADDR_W'(AFVC_OFS_B1_C)) begin
        band_coef_c_reg[0] <= pwdata[15:0];
      end else if (paddr == ADDR_W'(AFVC_OFS_B2_AB)) begin
        band_coef_a_reg[1] <= pwdata[15:0];
        band_coef_b_reg[1] <= pwdata[31:16];
      end else if (paddr == ADDR_W'(AFVC_OFS_B2_C)) begin
        band_coef_c_reg[1] <= pwdata[15:0];
      end else if (paddr == ADDR_W'(AFVC_OFS_IN_VOL)) begin
        input_volume_code_reg <= pwdata[7:0];
      end else if (paddr == ADDR_W'(AFVC_OFS_OUT_VOL)) begin
        output_volume_code_reg <= pwdata[7:0];
      end
    end
  end

  // Sample sequencer; a sample strobe arriving while busy is dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      work_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (sample_in_valid) begin
            work_reg <= sample_in;
            state_reg <= ST_HPC;
          end
        end
        ST_HPC: begin
          work_reg <= stage_out;
          state_reg <= ST_HPP;
        end
        ST_HPP: begin
          work_reg <= stage_out;
          state_reg <= ST_EQ1;
        end
        ST_EQ1: begin
          work_reg <= stage_out;
          state_reg <= ST_EQ2;
        end
        ST_EQ2: begin
          work_reg <= stage_out;
          state_reg <= ST_VOL;
        end
        ST_VOL: begin
          work_reg <= stage_out;
          state_reg <= ST_ATT;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // With level control on, that block is outside this design, so the stage passes at 0dB.
  always_comb begin
    vol_code = AFVC_RST_VOL;
    if (path_select && !record_level_ctrl_enable) begin
      vol_code = in_vol_applied_reg;
    end else if (!path_select && !playback_level_ctrl_enable) begin
      vol_code = out_vol_applied_reg;
    end
  end

  always_comb begin
    hp_result = afvc_highpass(work_reg, (state_reg == ST_HPC) ? hpc_x_reg : hpp_x_reg,
      (state_reg == ST_HPC) ? hpc_y_reg : hpp_y_reg, hp_coef_a_reg, hp_coef_b_reg);
    eq_w = (state_reg == ST_EQ2) ?
      afvc_band(work_reg, eq_x2_reg[1], eq_w1_reg[1], eq_w2_reg[1], band_coef_a_reg[1], band_coef_b_reg[1],
        band_coef_c_reg[1]) :
      afvc_band(work_reg, eq_x2_reg[0], eq_w1_reg[0], eq_w2_reg[0], band_coef_a_reg[0], band_coef_b_reg[0],
        band_coef_c_reg[0]);
    stage_out = work_reg;
    case (state_reg)
      ST_HPC: stage_out = conv_hp_on ? hp_result : work_reg;
      ST_HPP: stage_out = pre_hp_on ? hp_result : work_reg;
      ST_EQ1: stage_out = band_on[0] ? afvc_sat(36'(work_reg) + 36'(eq_w)) : work_reg;
      ST_EQ2: stage_out = band_on[1] ? afvc_sat(36'(work_reg) + 36'(eq_w)) : work_reg;
      ST_VOL: stage_out = afvc_volume(work_reg, vol_code);
      default: stage_out = work_reg;
    endcase
  end

  // Filter memories clear while a stage is off, so it restarts cleanly on the next sample.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hpc_x_reg <= '0;
      hpc_y_reg <= '0;
      hpp_x_reg <= '0;
      hpp_y_reg <= '0;
      eq_x1_reg <= '{default: '0};
      eq_x2_reg <= '{default: '0};
      eq_w1_reg <= '{default: '0};
      eq_w2_reg <= '{default: '0};
    end else begin
      if (!conv_hp_on) begin
        hpc_x_reg <= '0;
        hpc_y_reg <= '0;
      end else if (state_reg == ST_HPC) begin
        hpc_x_reg <= work_reg;
        hpc_y_reg <= hp_result;
      end
      if (!pre_hp_on) begin
        hpp_x_reg <= '0;
        hpp_y_reg <= '0;
      end else if (state_reg == ST_HPP) begin
        hpp_x_reg <= work_reg;
        hpp_y_reg <= hp_result;
      end
      for (int i = 0; i < 2; i++) begin
        if (!band_on[i]) begin
          eq_x1_reg[i] <= '0;
          eq_x2_reg[i] <= '0;
          eq_w1_reg[i] <= '0;
          eq_w2_reg[i] <= '0;
        end else if ((i == 0 && state_reg == ST_EQ1) || (i == 1 && state_reg == ST_EQ2)) begin
          eq_x1_reg[i] <= work_reg;
          eq_x2_reg[i] <= eq_x1_reg[i];
          eq_w1_reg[i] <= eq_w;
          eq_w2_reg[i] <= eq_w1_reg[i];
        end
      end
    end
  end

  assign vol_step = (state_reg == ST_VOL);
  assign zero_cross = (work_reg == 16'sh0000) || (work_reg[15] != prev_vol_in_reg[15]);
  assign zc_limit = AFVC_ZC_BASE_SAMPLES << zero_cross_timeout_sel;
  assign in_pending = (input_volume_code_reg != in_vol_applied_reg);
  assign out_pending = (output_volume_code_reg != out_vol_applied_reg);
  assign in_restart = wr_en && (paddr == ADDR_W'(AFVC_OFS_IN_VOL)) &&
    (pwdata[7:0] != input_volume_code_reg);
  assign out_restart = wr_en && (paddr == ADDR_W'(AFVC_OFS_OUT_VOL)) &&
    (pwdata[7:0] != output_volume_code_reg);
  assign in_apply = vol_step && in_pending && !in_restart &&
    (zero_cross || in_zc_cnt_reg >= zc_limit - 11'h001);
  assign out_apply = vol_step && out_pending && !out_restart &&
    (zero_cross || out_zc_cnt_reg >= zc_limit - 11'h001);

  // A restart write wins over a sample arriving in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_zc_cnt_reg <= '0;
      out_zc_cnt_reg <= '0;
      in_vol_applied_reg <= AFVC_RST_VOL;
      out_vol_applied_reg <= AFVC_RST_VOL;
      prev_vol_in_reg <= '0;
    end else begin
      if (vol_step) begin
        prev_vol_in_reg <= work_reg;
      end
      if (in_restart || in_apply || !in_pending) begin
        in_zc_cnt_reg <= '0;
      end else if (vol_step) begin
        in_zc_cnt_reg <= in_zc_cnt_reg + 11'h001;
      end
      if (out_restart || out_apply || !out_pending) begin
        out_zc_cnt_reg <= '0;
      end else if (vol_step) begin
        out_zc_cnt_reg <= out_zc_cnt_reg + 11'h001;
      end
      if (in_apply) begin
        in_vol_applied_reg <= input_volume_code_reg;
      end
      if (out_apply) begin
        out_vol_applied_reg <= output_volume_code_reg;
      end
    end
  end

  // Shifts give -6.02, -12.04 and -18.06dB, close to the table steps.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_out_reg <= '0;
      sample_out_valid_reg <= 1'b0;
    end else begin
      sample_out_valid_reg <= (state_reg == ST_ATT);
      if (state_reg == ST_ATT) begin
        sample_out_reg <= path_select ? work_reg : (work_reg >>> playback_attenuator_sel);
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign sample_out = sample_out_reg;
  assign sample_out_valid = sample_out_valid_reg;

endmodule // afvc_top

// >>> testbench/afvc_conv_model.sv
// Converter-side sample source and sink model.
`timescale 1ns/100ps
module afvc_conv_model (
  input wire logic pclk,
  input wire logic signed [15:0] sample_out,
  input wire logic sample_out_valid,
  output logic signed [15:0] sample_in,
  output logic sample_in_valid
);
  initial begin
    sample_in = 16'h0000;
    sample_in_valid = 1'b0;
  end
  // The next sample follows only three cycles after the output; the sequencer is already back in ST_IDLE by then.
  task automatic xfer(input logic signed [15:0] x, output logic signed [15:0] y, output logic ok);
    int n;
    sample_in <= x;
    sample_in_valid <= 1'b1;
    @(posedge pclk);
    sample_in_valid <= 1'b0;
    // Past its hold time the line shows the inverse, so a late capture is caught.
    sample_in <= ~x;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sample_out_valid !== 1'b1 && n < 20);
    y = sample_out;
    ok = (n < 20);
    repeat (3) @(posedge pclk);
  endtask
endmodule // afvc_conv_model

// >>> testbench/afvc_asserts.sv
// Port-level assertions for the audio filter and volume chain.
`timescale 1ns/100ps
module afvc_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic signed [15:0] sample_in,
  input wire logic sample_in_valid,
  input wire logic signed [15:0] sample_out,
  input wire logic sample_out_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ack; psel && !penable |=> pready; endproperty
  property p_once; pready |=> !pready; endproperty
  property p_rdz; !pready |-> prdata == 32'h0; endproperty
  property p_err; pready && (paddr[1:0] != 2'b00 || paddr > 'h24) |-> pslverr; endproperty
  property p_ok; pready && paddr[1:0] == 2'b00 && paddr <= 'h24 |-> !pslverr; endproperty
  property p_lat; sample_out_valid |-> $past(sample_in_valid, 7); endproperty
  property p_pulse; sample_out_valid |=> !sample_out_valid; endproperty
  property p_hold; !sample_out_valid |-> $stable(sample_out); endproperty
  a_ack: assert property (p_ack) else $error("no ready after setup");
  a_once: assert property (p_once) else $error("ready too long");
  a_rdz: assert property (p_rdz) else $error("read data outside access");
  a_err: assert property (p_err) else $error("bad address accepted");
  a_ok: assert property (p_ok) else $error("good address refused");
  a_lat: assert property (p_lat) else $error("output latency wrong");
  a_pulse: assert property (p_pulse) else $error("output valid too long");
  a_hold: assert property (p_hold) else $error("output changed without valid");
  c_out: cover property (sample_out_valid);
  c_err: cover property (pready && pslverr);
  c_wr: cover property (pready && pwrite);
endmodule // afvc_asserts
bind afvc_top afvc_asserts #(.ADDR_W(ADDR_W)) i_afvc_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sample_in(sample_in), .sample_in_valid(sample_in_valid), .sample_out(sample_out),
  .sample_out_valid(sample_out_valid));

// >>> testbench/audio_filter_volume_chain_test.sv
// Self-checking testbench of the audio filter and volume chain.
`timescale 1ns/100ps
module audio_filter_volume_chain_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, sample_out_valid, sample_in_valid, e;
  logic signed [15:0] sample_in, sample_out;
  logic [15:0] y;
  int n_fail = 0, tests_run = 0, seed = 56, k, i, x, x1, x2;
  always #10 pclk = ~pclk;
  afvc_top i_afvc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_in(sample_in),
    .sample_in_valid(sample_in_valid), .sample_out(sample_out), .sample_out_valid(sample_out_valid));
  afvc_conv_model i_afvc_conv_model (.pclk(pclk), .sample_out(sample_out), .sample_out_valid(sample_out_valid),
    .sample_in(sample_in), .sample_in_valid(sample_in_valid));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 20, 1, "no ready");
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic snd(input int v);
    logic signed [15:0] r;
    logic ok;
    i_afvc_conv_model.xfer(v[15:0], r, ok);
    y = r;
    chk(ok, 1, "sample lost");
  endtask
  function automatic logic [15:0] sat(input int v);
    return v > 32767 ? 16'h7fff : v < -32768 ? 16'h8000 : v[15:0];
  endfunction
  // Volume on one path: mute at a crossing, then restart and timeout of a pending change.
  task automatic vt(input int p);
    int lim, j;
    logic [7:0] va;
    lim = 128 << p;
    va = p ? 8'h18 : 8'h1c;
    wr(8'h00, (p << 6) | (p << 9));
    // A positive sample first, so that the next one cannot count as a crossing.
    snd(100);
    wr(va, 32'h0);
    snd(100);
    chk(y, 100, "old volume kept");
    rd(8'h20);
    chk(q[17 - p], 1, "pending");
    snd(-100);
    snd(50);
    chk(y, 0, "mute");
    wr(8'h00, (p << 6) | (p << 9) | (256 >> p));
    snd(50);
    chk(y, 50, "level control on");
    wr(8'h00, (p << 6) | (p << 9));
    wr(va, 32'h50);
    repeat (10) snd(7);
    wr(va, 32'h60);
    for (j = 0; j < lim - 1; j++) begin
      if (j == lim / 2) wr(va, 32'h60);
      snd(7 + j % 50);
    end
    rd(8'h20);
    chk(q[17 - p], 1, "restart");
    snd(9);
    rd(8'h20);
    chk((q >> (8 - 8 * p)) & 32'hff, 32'h60, "timeout");
  endtask
  initial begin
    #1000000;
    chk(0, 1, "watchdog");
    finish_test;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00);
    chk(q, 32'h40, "ctrl reset");
    rd(8'h18);
    chk(q, 32'h91, "in vol reset");
    rd(8'h1c);
    chk(q, 32'h91, "out vol reset");
    rd(8'h20);
    chk(q & 32'hffff, 32'h9191, "applied reset");
    apb(1'b1, 8'h28, 32'h0, q, e);
    chk(e, 1, "unmapped");
    apb(1'b0, 8'h02, 32'h0, q, e);
    chk(e, 1, "unaligned");
    x = $random(seed);
    wr(8'h04, x);
    rd(8'h04);
    chk(q, x & 32'h3fff3fff, "hp coef width");
    // Codes 0 to 3 on playback, then code 3 on record where the attenuator must not act.
    for (k = 0; k < 5; k++) begin
      wr(8'h00, k < 4 ? k << 11 : 32'h40 | (3 << 11));
      repeat (6) begin
        x = $random(seed) % 32768;
        snd(x);
        chk(y, sat(k < 4 ? x >>> k : x), "attenuator");
      end
    end
    // Converter stage, pre-equalizer stage, band one and band two, each alone.
    for (k = 0; k < 4; k++) begin
      wr(8'h00, 32'h40);
      // These coefficients put cut-off and centre at a quarter of the sample rate, gain two, all in range.
      wr(k < 2 ? 8'h04 : 8'h08 << (k - 2), k < 2 ? 32'h1000 : 32'h2000);
      wr(8'h00, k == 0 ? 32'h45 : k == 1 ? 32'h4a : k == 2 ? 32'h58 : 32'h68);
      x1 = 0;
      x2 = 0;
      for (i = 0; i < 12; i++) begin
        x = k < 2 ? $random(seed) % 8000 : $random(seed) % 32768;
        snd(x);
        if (i > 2) chk(y, sat(k < 2 ? (x - x1) >>> 1 : 2 * x - x2), "filter");
        x2 = x1;
        x1 = x;
      end
    end
    vt(0);
    vt(1);
    finish_test;
  end
endmodule // audio_filter_volume_chain_test
